// *** logic/ccmsw_pkg.sv ***
// Constants for the calibration coefficient sign and top-bit words.
// Assumes a word-wide command port from the serial interface decoder on the same clock.
package ccmsw_pkg;

   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 16;
   localparam int MAG_W     = 17;
   localparam int COEF_W    = 18;
   localparam int NCOEF     = 10;
   localparam int MEM_AW    = 4;
   localparam int MEM_DEPTH = 16;

   typedef logic [ADDR_W-1:0] ccmsw_addr_t;
   typedef logic [DATA_W-1:0] ccmsw_word_t;

   // ----------------------------------------------------------------
   // Memory word addresses
   // ----------------------------------------------------------------
   localparam ccmsw_addr_t ADDR_SIGN_BRIDGE = 8'h03;
   localparam ccmsw_addr_t ADDR_SIGN_TEMP   = 8'h04;
   localparam ccmsw_addr_t ADDR_LOW_FIRST   = 8'h05;
   localparam ccmsw_addr_t ADDR_LOW_LAST    = 8'h0E;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int          CURVE_BIT      = 14;
   localparam int          SETTL_BIT      = 15;
   localparam ccmsw_word_t TEMP_USED_MASK = 16'h003F;
   localparam ccmsw_word_t RESET_WORD     = 16'h0000;

   // ----------------------------------------------------------------
   // Coefficient map, index order is the output port order:
   // 0 bridge offset, 1 bridge gain, 2 gain drift first, 3 offset drift first,
   // 4 offset drift second, 5 gain drift second, 6 bridge second order,
   // 7 temp sensor gain, 8 temp sensor second order, 9 temp sensor offset
   // ----------------------------------------------------------------
   localparam ccmsw_addr_t COEF_LOW_ADDR [NCOEF] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                                                    8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0C};
   localparam logic        COEF_IN_TEMP  [NCOEF] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                                    1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   // Position of bit 16; the sign sits one above it
   localparam int          COEF_MSB_POS  [NCOEF] = '{0, 2, 4, 6, 8, 10, 12, 0, 2, 4};

endpackage

// *** logic/ccmsw_mem.sv ***
// Small word memory holding the lower 16-bit coefficient words.
// Assumes write and read never share a cycle; read data are registered.
`timescale 1ns/10ps
module ccmsw_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             wr_en,
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [WIDTH-1:0]            rdata;
   } ccmsw_mem_st_t;

   ccmsw_mem_st_t st_q;
   ccmsw_mem_st_t st_d;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Reset returns the erased default of all zeros
   always_comb begin
      st_d = st_q;
      if (wr_en) begin
         st_d.words[addr] = wdata;
      end
      if (rd_en) begin
         st_d.rdata = st_q.words[addr];
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;

endmodule // ccmsw_mem

// *** logic/ccmsw_bank.sv ***
// Calibration coefficient bank: the two sign/top-bit words, the lower words,
// and the assembled signed coefficients for the correction processor.
// Assumes the serial interface decoder drives the word port on mclk.
//
// What this block does
// - Bit 0 of the bridge sign word is bit 16 of the bridge offset magnitude, above word 05.
// - Bit 1 of the bridge sign word is the bridge offset sign, set meaning negative.
// - Bits 2 and 3 of the bridge sign word are bit 16 and sign of bridge gain, over word 06.
// - Bits 4 and 5 of the bridge sign word are bit 16 and sign of gain drift first, over 07.
// - Bits 6 and 7 of the bridge sign word are bit 16 and sign of offset drift first, over 08.
// - Bits 8 and 9 of the bridge sign word are bit 16 and sign of offset drift second, over 09.
// - Bits 10 and 11 of the bridge sign word are bit 16 and sign of gain drift second, over 0A.
// - Bits 12 and 13 of the bridge sign word are bit 16 and sign of bridge second order, over 0B.
// - Bit 14 of the bridge sign word picks the curve: zero parabolic, one S-shaped.
// - Bit 15 of the bridge sign word is the settling term sign, set meaning negative.
// - Bits 0 and 1 of the temp sign word are bit 16 and sign of sensor gain, over word 0D.
// - Bits 2 and 3 of the temp sign word are bit 16 and sign of sensor second order, over 0E.
// - Bits 4 and 5 of the temp sign word are bit 16 and sign of sensor offset, over word 0C.
// - Every sign bit means positive when clear and negative when set.
// - Word 05 supplies magnitude bits 15 to 0 of the bridge offset.
`timescale 1ns/10ps
module ccmsw_bank
   import ccmsw_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              req_wr,
   input  wire logic              req_rd,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata,
   output logic      [COEF_W-1:0] bridge_offset_coef,
   output logic      [COEF_W-1:0] bridge_gain_coef,
   output logic      [COEF_W-1:0] gain_temp_drift_first,
   output logic      [COEF_W-1:0] offset_temp_drift_first,
   output logic      [COEF_W-1:0] offset_temp_drift_second,
   output logic      [COEF_W-1:0] gain_temp_drift_second,
   output logic      [COEF_W-1:0] bridge_second_order_coef,
   output logic      [COEF_W-1:0] temp_sensor_gain_coef,
   output logic      [COEF_W-1:0] temp_sensor_second_order_coef,
   output logic      [COEF_W-1:0] temp_sensor_offset_coef,
   output logic                   curve_shape_select,
   output logic                   settling_term_negative
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0]             sign_bridge;
      logic [DATA_W-1:0]             sign_temp;
      logic [NCOEF-1:0][DATA_W-1:0]  low;
      logic [NCOEF-1:0][COEF_W-1:0]  coef;
      logic                          curve;
      logic                          settl_neg;
      logic                          rd_pend;
      logic                          rd_from_mem;
      logic [DATA_W-1:0]             rd_hold;
      logic                          rsp_valid;
      logic [DATA_W-1:0]             rsp_rdata;
   } ccmsw_st_t;

   ccmsw_st_t         st_q;
   ccmsw_st_t         st_d;
   logic [DATA_W-1:0] mem_rdata;
   logic              mem_wr;
   logic              mem_rd;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // True for the addresses of the lower coefficient words
   function automatic logic is_low_addr(input logic [ADDR_W-1:0] a);
      return (a >= ADDR_LOW_FIRST) && (a <= ADDR_LOW_LAST);
   endfunction

   // Sign-magnitude to two's complement; a negative zero yields zero
   function automatic logic [COEF_W-1:0] apply_sign(input logic             neg,
                                                     input logic [MAG_W-1:0] mag);
      logic [COEF_W-1:0] ext;
      ext = {1'b0, mag};
      return neg ? (~ext + 18'h0_0001) : ext;
   endfunction

   // ----------------------------------------------------------------
   // Lower word memory
   // ----------------------------------------------------------------
   // A write wins over a read in the same cycle, so the port never conflicts
   assign mem_wr = req_wr && is_low_addr(req_addr);
   assign mem_rd = !req_wr && req_rd && is_low_addr(req_addr);

   ccmsw_mem #(
      .WIDTH (DATA_W),
      .DEPTH (MEM_DEPTH),
      .AW    (MEM_AW)
   ) u_mem (
      .mclk  (mclk),
      .rst_b (rst_b),
      .wr_en (mem_wr),
      .rd_en (mem_rd),
      .addr  (req_addr[MEM_AW-1:0]),
      .wdata (req_wdata),
      .rdata (mem_rdata)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       neg;
      logic       msb;
      logic [DATA_W-1:0] word;
      neg  = 1'b0;
      msb  = 1'b0;
      word = '0;
      st_d = st_q;
      st_d.rsp_valid = 1'b0;
      st_d.rd_pend   = 1'b0;

      // Word writes; a copy of each lower word is kept for the arithmetic
      if (req_wr) begin
         if (req_addr == ADDR_SIGN_BRIDGE) begin
            st_d.sign_bridge = req_wdata;
         end else if (req_addr == ADDR_SIGN_TEMP) begin
            st_d.sign_temp = req_wdata & TEMP_USED_MASK;
         end
         for (int k = 0; k < NCOEF; k++) begin
            if (req_addr == COEF_LOW_ADDR[k]) begin
               st_d.low[k] = req_wdata;
            end
         end
      end else if (req_rd) begin
         // Reads of unmapped words answer zero
         st_d.rd_pend     = 1'b1;
         st_d.rd_from_mem = is_low_addr(req_addr);
         if (req_addr == ADDR_SIGN_BRIDGE) begin
            st_d.rd_hold = st_q.sign_bridge;
         end else if (req_addr == ADDR_SIGN_TEMP) begin
            st_d.rd_hold = st_q.sign_temp;
         end else begin
            st_d.rd_hold = RESET_WORD;
         end
      end

      // Second stage of a read: memory data is ready by now
      if (st_q.rd_pend) begin
         st_d.rsp_valid = 1'b1;
         st_d.rsp_rdata = st_q.rd_from_mem ? mem_rdata : st_q.rd_hold;
      end

      // Coefficient assembly from bit 16, sign and the lower word
      for (int k = 0; k < NCOEF; k++) begin
         word = COEF_IN_TEMP[k] ? st_q.sign_temp : st_q.sign_bridge;
         msb  = word[COEF_MSB_POS[k]];
         neg  = word[COEF_MSB_POS[k] + 1];
         st_d.coef[k] = apply_sign(neg, {msb, st_q.low[k]});
      end

      // Mode bits of the bridge word
      st_d.curve     = st_q.sign_bridge[CURVE_BIT];
      st_d.settl_neg = st_q.sign_bridge[SETTL_BIT];
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Every field starts at zero, the documented default of each bit
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state flops
   // ----------------------------------------------------------------
   assign rsp_valid                     = st_q.rsp_valid;
   assign rsp_rdata                     = st_q.rsp_rdata;
   assign bridge_offset_coef            = st_q.coef[0];
   assign bridge_gain_coef              = st_q.coef[1];
   assign gain_temp_drift_first         = st_q.coef[2];
   assign offset_temp_drift_first       = st_q.coef[3];
   assign offset_temp_drift_second      = st_q.coef[4];
   assign gain_temp_drift_second        = st_q.coef[5];
   assign bridge_second_order_coef      = st_q.coef[6];
   assign temp_sensor_gain_coef         = st_q.coef[7];
   assign temp_sensor_second_order_coef = st_q.coef[8];
   assign temp_sensor_offset_coef       = st_q.coef[9];
   assign curve_shape_select            = st_q.curve;
   assign settling_term_negative        = st_q.settl_neg;

endmodule // ccmsw_bank

// *** tb/ccmsw_bank_assertions.sv ***
// Checker on the coefficient sign-word bank ports.
// Assumes one clock, mclk, and synchronous active-low rst_b.
`timescale 1ns/10ps
module ccmsw_chk
   import ccmsw_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rst_b,
   input wire logic              req_wr,
   input wire logic              req_rd,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic              rsp_valid,
   input wire logic [DATA_W-1:0] rsp_rdata,
   input wire logic [COEF_W-1:0] bridge_offset_coef,
   input wire logic [COEF_W-1:0] temp_sensor_gain_coef,
   input wire logic              curve_shape_select,
   input wire logic              settling_term_negative
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Requests; every effect lands two edges on
   // ----------------------------------------
   sequence s_rd; req_rd && !req_wr; endsequence
   sequence s_wr_br; req_wr && req_addr == 8'h03; endsequence
   sequence s_wr_tp; req_wr && req_addr == 8'h04; endsequence
   a_read_answer: assert property (s_rd |-> ##2 rsp_valid)
      else $error("read got no answer");
   a_valid_cause: assert property (rsp_valid |-> $past(req_rd && !req_wr, 2))
      else $error("answer without read");
   a_temp_unused: assert property (s_rd ##0 req_addr == 8'h04 |-> ##2 rsp_rdata[15:6] == 10'h000)
      else $error("unused temp bits read nonzero");
   a_curve_follow: assert property (s_wr_br |-> ##2 curve_shape_select == $past(req_wdata[14], 2))
      else $error("curve select wrong");
   a_settle_follow: assert property (s_wr_br |-> ##2 settling_term_negative == $past(req_wdata[15], 2))
      else $error("settling sign wrong");
   // Only a bridge-word write may move the curve choice
   a_curve_hold: assert property ($changed(curve_shape_select) |-> $past(req_wr && req_addr == 8'h03, 2))
      else $error("curve changed alone");
   a_offset_neg: assert property (s_wr_br ##0 req_wdata[1:0] == 2'b11 |-> ##2 bridge_offset_coef[17])
      else $error("offset not negative");
   a_offset_pos: assert property (s_wr_br ##0 !req_wdata[1] |-> ##2 !bridge_offset_coef[17])
      else $error("offset not positive");
   a_tgain_neg: assert property (s_wr_tp ##0 req_wdata[1:0] == 2'b11 |-> ##2 temp_sensor_gain_coef[17])
      else $error("sensor gain not negative");
   // Reset must clear even while the default disable is active
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !rsp_valid && !curve_shape_select
                                   && bridge_offset_coef == 18'h0_0000)
      else $error("outputs not cleared by reset");
endmodule // ccmsw_chk

bind ccmsw_bank ccmsw_chk i_ccmsw_chk (
   .mclk(mclk), .rst_b(rst_b), .req_wr(req_wr), .req_rd(req_rd), .req_addr(req_addr),
   .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
   .bridge_offset_coef(bridge_offset_coef), .temp_sensor_gain_coef(temp_sensor_gain_coef),
   .curve_shape_select(curve_shape_select), .settling_term_negative(settling_term_negative)
);

// *** tb/ccmsw_master.sv ***
// Calibration master model on the bank's word port.
// Assumes the bench calls its tasks; drives on falling mclk edges.
`timescale 1ns/10ps
module ccmsw_master
   import ccmsw_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rsp_valid,
   input  wire logic [DATA_W-1:0] rsp_rdata,
   output logic                   req_wr,
   output logic                   req_rd,
   output logic      [ADDR_W-1:0] req_addr,
   output logic      [DATA_W-1:0] req_wdata
);
   initial begin
      req_wr = 1'b0;
      req_rd = 1'b0;
      req_addr = 8'h00;
      req_wdata = 16'h0000;
   end
   // Write; idle cycles first let the master act slowly
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input int idle);
      repeat (idle) @(negedge mclk);
      @(negedge mclk);
      req_wr <= 1'b1;
      req_addr <= a;
      req_wdata <= d;
      @(negedge mclk);
      req_wr <= 1'b0;
      req_addr <= ~a; // Released lines flip, stale values never pass
      req_wdata <= ~d;
   endtask
   // Read; bounded wait for the answer pulse
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
      @(negedge mclk);
      req_rd <= 1'b1;
      req_addr <= a;
      @(negedge mclk);
      req_rd <= 1'b0;
      req_addr <= ~a;
      ok = 1'b0;
      d = 16'h0000;
      for (int n = 0; n < 4 && !ok; n++) begin
         @(negedge mclk);
         if (rsp_valid === 1'b1) begin
            ok = 1'b1;
            d = rsp_rdata;
         end
      end
   endtask
endmodule // ccmsw_master

// *** tb/ccmsw_bank_bench.sv ***
// Self-checking bench for the coefficient sign-word bank.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/10ps
module ccmsw_bank_bench;
   import ccmsw_pkg::*;
   logic              mclk = 1'b0;
   logic              rst_b = 1'b0;
   wire               req_wr, req_rd, rsp_valid, curve, settle;
   wire  [ADDR_W-1:0] req_addr;
   wire  [DATA_W-1:0] req_wdata, rsp_rdata;
   wire  [COEF_W-1:0] cf [NCOEF];
   int                n_mismatch = 0;
   int                checked = 0;
   // Lower-word address and top-bit position of each coefficient
   localparam logic [7:0] LOW_ADDR [NCOEF] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                                               8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0C};
   localparam int         POS [NCOEF] = '{0, 2, 4, 6, 8, 10, 12, 0, 2, 4};
   always #10 mclk = ~mclk;
   ccmsw_bank i_ccmsw_bank (.mclk(mclk), .rst_b(rst_b), .req_wr(req_wr), .req_rd(req_rd),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .bridge_offset_coef(cf[0]), .bridge_gain_coef(cf[1]), .gain_temp_drift_first(cf[2]),
      .offset_temp_drift_first(cf[3]), .offset_temp_drift_second(cf[4]),
      .gain_temp_drift_second(cf[5]), .bridge_second_order_coef(cf[6]),
      .temp_sensor_gain_coef(cf[7]), .temp_sensor_second_order_coef(cf[8]),
      .temp_sensor_offset_coef(cf[9]), .curve_shape_select(curve),
      .settling_term_negative(settle));
   ccmsw_master i_ccmsw_master (.mclk(mclk), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .req_wr(req_wr), .req_rd(req_rd), .req_addr(req_addr), .req_wdata(req_wdata));
   // ----------------------------------------
   // Compare, read and verdict tasks
   // ----------------------------------------
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_coef(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t coef got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      bit          ok;
      i_ccmsw_master.rd(a, d, ok);
      if (!ok) begin
         n_mismatch++;
         $display("[ERR] %0t no read answer", $time);
         print_verdict();
      end else
         cmp_word(d, exp);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] low;
      logic [17:0] exp;
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      for (int i = 0; i < NCOEF; i++)
         cmp_coef(cf[i], 18'h0_0000);
      rd_chk(8'h03, 16'h0000);
      rd_chk(8'h04, 16'h0000);
      $display("test reset defaults done");
      // Each coefficient: top bit set, then positive and negative sign
      for (int i = 0; i < NCOEF; i++) begin
         low = 16'hA5C3 ^ 16'(i);
         i_ccmsw_master.wr(LOW_ADDR[i], low, 0);
         for (int s = 0; s < 2; s++) begin
            i_ccmsw_master.wr(i < 7 ? 8'h03 : 8'h04, 16'(1 << POS[i]) | 16'(s << (POS[i] + 1)), s);
            repeat (2) @(negedge mclk);
            exp = s ? -{1'b0, 1'b1, low} : {1'b0, 1'b1, low};
            cmp_coef(cf[i], exp);
         end
         rd_chk(LOW_ADDR[i], low);
      end
      // Negative zero must come out as zero
      i_ccmsw_master.wr(8'h05, 16'h0000, 0);
      i_ccmsw_master.wr(8'h03, 16'h0002, 0);
      repeat (2) @(negedge mclk);
      cmp_coef(cf[0], 18'h0_0000);
      $display("test coefficients done");
      for (int k = 0; k < 4; k++) begin
         i_ccmsw_master.wr(8'h03, {k[1:0], 14'h0000}, 0);
         repeat (2) @(negedge mclk);
         cmp_word(16'(curve), 16'(k[0]));
         cmp_word(16'(settle), 16'(k[1]));
      end
      $display("test curve and settling done");
      // Unused temp bits, unmapped places
      i_ccmsw_master.wr(8'h04, 16'hFFFF, 0);
      rd_chk(8'h04, 16'h003F);
      exp = -{1'b0, 1'b1, 16'hA5C3 ^ 16'h0007};
      cmp_coef(cf[7], exp);
      i_ccmsw_master.wr(8'h20, 16'hFFFF, 0);
      rd_chk(8'h20, 16'h0000);
      rd_chk(8'h02, 16'h0000);
      $display("test refusals done");
      // Second reset in mid-run clears everything
      @(negedge mclk);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      cmp_coef(cf[0], 18'h0_0000);
      rd_chk(8'h03, 16'h0000);
      $display("test second reset done");
      print_verdict();
   end
endmodule // ccmsw_bank_bench
